// ### common/dme_pkg.sv
// Constants, field layouts and record type for the distortion alarm block
//
// Functional notes
// - Sample blocking once at each program cycle
// - Pick-up without blocking raises start, starts timer
// - Pick-up under blocking raises blocked only
// - Blocking after start releases like pick-up drop
// - Per-channel delay, 5 ms steps, default 10 s
// - ON and OFF events for seven status outputs
// - Event mask selects which events reach the event stream
// - Every stored event carries a time stamp
// - Start, alarm, blocked counters, clearable by command
// - Twelve-record history, oldest overwritten
// - Records only on ON transitions
// - Record holds time, event, phase THD, group
// - Status outputs usable directly and by logic
// - Pick-up releases below 97 % of threshold
// - Disabled channel never picks up or alarms
package dme_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int DELAY_STEP_NS = 5000000;
  localparam int STEP_CYCLES = DELAY_STEP_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 20;

  // ************************************************************
  // Widths and sizes
  // ************************************************************
  localparam int NCH = 3;
  localparam int NSTAT = 7;
  localparam int NEVT = 14;
  localparam int DLY_W = 19;
  localparam int THD_W = 14;
  localparam int CNT_W = 16;
  localparam int TS_W = 32;
  localparam int GRP_W = 3;
  localparam int HIST_DEPTH = 12;
  localparam int HIST_IDX_W = 4;
  localparam logic [HIST_IDX_W-1:0] HIST_LAST = 4'hB;

  // ************************************************************
  // Reset values and fixed ratios
  // ************************************************************
  localparam logic [DLY_W-1:0] DELAY_RESET = 19'h007D0;
  localparam logic [THD_W-1:0] THR_RESET = 14'h03E8;
  localparam logic [NCH-1:0] ENABLE_RESET = 3'h7;
  localparam logic [NEVT-1:0] EVT_MASK_RESET = 14'h3FFF;
  localparam logic [6:0] FULL_PCT = 7'h64;
  localparam logic [6:0] HYST_PCT = 7'h61;

  // ************************************************************
  // Register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DELAY0 = 8'h04;
  localparam logic [7:0] ADDR_THR0 = 8'h10;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_CNT0 = 8'h24;
  localparam logic [7:0] ADDR_INT_STAT = 8'h30;
  localparam logic [7:0] ADDR_INT_MASK = 8'h34;
  localparam logic [7:0] ADDR_HIST_SEL = 8'h38;
  localparam logic [7:0] ADDR_HIST_TIME = 8'h3C;
  localparam logic [7:0] ADDR_HIST_INFO = 8'h40;
  localparam logic [7:0] ADDR_HIST_THD01 = 8'h44;
  localparam logic [7:0] ADDR_HIST_THD2 = 8'h48;

  // Field positions
  localparam int CTRL_CLR_BIT = 3;
  localparam int STAT_BLK_BIT = 6;
  localparam int INT_START_BIT = 0;
  localparam int INT_ALARM_BIT = 1;
  localparam int INT_BLK_BIT = 2;
  localparam int INFO_GRP_LSB = 8;
  localparam int THD_HI_LSB = 16;

  // One fault record
  typedef struct packed {
    logic [TS_W-1:0] stamp;
    logic [2:0] code;
    logic [GRP_W-1:0] group;
    logic [NCH-1:0][THD_W-1:0] thd;
  } dme_rec_type;

endpackage

// ### rtl/dme_channel.sv
// One alarm channel: pick-up with hysteresis, blocking and delay timer
`timescale 1ns/1ps
`default_nettype none
module dme_channel
  import dme_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Program cycle
  input wire logic tick,
  input wire logic blk,
  // Settings
  input wire logic enable,
  input wire logic [THD_W-1:0] threshold,
  input wire logic [DLY_W-1:0] delay,
  // Measurement
  input wire logic [THD_W-1:0] measured,
  // Status
  output logic start,
  output logic alarm,
  output logic blocked
);

  typedef struct packed {
    logic pick;
    logic start;
    logic alarm;
    logic blocked;
    logic [DLY_W-1:0] timer;
  } dme_ch_type;

  dme_ch_type s_reg;
  dme_ch_type s_next;
  logic above;
  logic held;

  // ************************************************************
  // Next state, evaluated once per program cycle
  // ************************************************************
  always_comb
  begin
    above = measured > threshold;
    held = (21'(measured) * 21'(FULL_PCT)) >=
           (21'(threshold) * 21'(HYST_PCT));
    s_next = s_reg;
    if (tick)
    begin
      s_next.pick = enable && (s_reg.pick ? held : above);
      if (!s_next.pick)
      begin
        // Drop of pick-up releases everything
        s_next.start = 1'b0;
        s_next.alarm = 1'b0;
        s_next.blocked = 1'b0;
        s_next.timer = '0;
      end
      else if (!s_reg.pick)
      begin
        // Fresh pick-up: blocking decides the path
        s_next.start = !blk;
        s_next.blocked = blk;
        s_next.timer = '0;
      end
      else if (s_reg.start && blk)
      begin
        // Late blocking clears start, alarm and timer like a pick-up drop, but sets blocked
        s_next.start = 1'b0;
        s_next.alarm = 1'b0;
        s_next.blocked = 1'b1;
        s_next.timer = '0;
      end
      else if (s_reg.blocked && !blk)
        s_next.blocked = 1'b0;
      else if (s_reg.start)
      begin
        // Saturate so a long fault never wraps the timer
        if (s_reg.timer != '1)
          s_next.timer = s_reg.timer + 1'b1;
        s_next.alarm = s_next.timer >= delay;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign start = s_reg.start;
  assign alarm = s_reg.alarm;
  assign blocked = s_reg.blocked;

endmodule
`default_nettype wire

// ### rtl/dme_distortion_monitor_event_block.sv
// Distortion alarm block: channels, events, counters, history, registers
`timescale 1ns/1ps
`default_nettype none
module dme_distortion_monitor_event_block
  import dme_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = STEP_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Blocking matrix and measurements
  input wire logic block_in,
  input wire logic [THD_W-1:0] thd_l1,
  input wire logic [THD_W-1:0] thd_l2,
  input wire logic [THD_W-1:0] thd_l3,
  input wire logic [THD_W-1:0] thd_residual_current_one,
  input wire logic [THD_W-1:0] thd_residual_current_two,
  input wire logic [TS_W-1:0] time_ms,
  input wire logic [GRP_W-1:0] setting_group,
  // Status outputs
  output logic [NCH-1:0] start_out,
  output logic [NCH-1:0] alarm_out,
  output logic blocked_out,
  // Event stream
  output logic [NEVT-1:0] evt_vec,
  output logic [TS_W-1:0] evt_time,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    logic blk_sample;
    logic [NCH-1:0] enable;
    logic [NCH-1:0][DLY_W-1:0] delay;
    logic [NCH-1:0][THD_W-1:0] thr;
    logic [NEVT-1:0] evt_mask;
    logic [NSTAT-1:0] stat_prev;
    logic [NEVT-1:0] evt_vec;
    logic [TS_W-1:0] evt_time;
    logic [NCH-1:0][CNT_W-1:0] cnt;
    logic [2:0] int_stat;
    logic [2:0] int_mask;
    logic [HIST_IDX_W-1:0] hist_sel;
    logic [HIST_IDX_W-1:0] hist_wr;
    logic [HIST_IDX_W-1:0] hist_fill;
    logic [NSTAT-1:0] pend;
    dme_rec_type snap;
    dme_rec_type [HIST_DEPTH-1:0] hist;
    logic [31:0] rdata;
  } dme_state_type;

  dme_state_type s_reg;
  dme_state_type s_next;

  logic tick;
  logic [NCH-1:0] ch_start;
  logic [NCH-1:0] ch_alarm;
  logic [NCH-1:0] ch_blocked;
  logic [NCH-1:0][THD_W-1:0] ch_meas;
  logic [NSTAT-1:0] stat_now;
  logic [NSTAT-1:0] rise;
  logic [NSTAT-1:0] fall;
  logic [NSTAT-1:0] pick_one;
  logic [THD_W-1:0] phase_max;
  logic [2:0] pick_code;
  logic [2:0] int_set;
  dme_rec_type rd_rec;

  // ************************************************************
  // Program cycle tick and channel measurements
  // ************************************************************
  assign tick = s_reg.tick_cnt == TICK_W'(TICK_CYCLES - 1);

  // Phase channel trips on the worst phase and holds until all fall
  always_comb
  begin
    phase_max = thd_l1;
    if (thd_l2 > phase_max)
      phase_max = thd_l2;
    if (thd_l3 > phase_max)
      phase_max = thd_l3;
  end

  assign ch_meas[0] = phase_max;
  assign ch_meas[1] = thd_residual_current_one;
  assign ch_meas[2] = thd_residual_current_two;

  // ************************************************************
  // Three independent channels
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      dme_channel u_ch (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .tick(tick),
        .blk(block_in),
        .enable(s_reg.enable[gi]),
        .threshold(s_reg.thr[gi]),
        .delay(s_reg.delay[gi]),
        .measured(ch_meas[gi]),
        .start(ch_start[gi]),
        .alarm(ch_alarm[gi]),
        .blocked(ch_blocked[gi])
      );
    end
  endgenerate

  // Status order: start x3, alarm x3, blocked
  assign stat_now = {(|ch_blocked), ch_alarm, ch_start};
  assign rise = stat_now & ~s_reg.stat_prev;
  assign fall = ~stat_now & s_reg.stat_prev;

  // Oldest-first is not needed: lowest pending status is recorded next
  assign pick_one = s_reg.pend & (~s_reg.pend + 7'h01);

  always_comb
  begin
    pick_code = 3'h0;
    for (int k = NSTAT - 1; k >= 0; k--)
      if (pick_one[k])
        pick_code = 3'(k);
  end

  // Start, alarm and blocked ON transitions raise interrupts
  assign int_set[INT_START_BIT] = |rise[2:0];
  assign int_set[INT_ALARM_BIT] = |rise[5:3];
  assign int_set[INT_BLK_BIT] = rise[STAT_BLK_BIT];

  // History slot under the read pointer, zero when out of range
  assign rd_rec = (s_reg.hist_sel <= HIST_LAST) ?
                  s_reg.hist[s_reg.hist_sel] : '0;

  // ************************************************************
  // Next state of the whole block
  // ************************************************************
  always_comb
  begin
    s_next = s_reg;
    s_next.tick_cnt = tick ? '0 : s_reg.tick_cnt + 1'b1;
    if (tick)
      s_next.blk_sample = block_in;
    s_next.stat_prev = stat_now;

    // Each status change gives an ON or an OFF event, masked
    for (int k = 0; k < NSTAT; k++)
    begin
      s_next.evt_vec[2*k] = rise[k] & s_reg.evt_mask[2*k];
      s_next.evt_vec[2*k+1] = fall[k] & s_reg.evt_mask[2*k+1];
    end
    if (|rise || |fall)
      s_next.evt_time = time_ms;

    // Counters; a clear in the same cycle as an event loses it
    for (int k = 0; k < NCH; k++)
      s_next.cnt[0] = s_next.cnt[0] + CNT_W'(rise[k]);
    for (int k = 0; k < NCH; k++)
      s_next.cnt[1] = s_next.cnt[1] + CNT_W'(rise[NCH+k]);
    s_next.cnt[2] = s_reg.cnt[2] + CNT_W'(rise[STAT_BLK_BIT]);
    if (reg_wr && reg_addr == ADDR_CTRL && reg_wdata[CTRL_CLR_BIT])
      s_next.cnt = '0;

    // Snapshot at the ON edge so queued records keep their moment
    if (|rise)
    begin
      s_next.snap.stamp = time_ms;
      s_next.snap.group = setting_group;
      s_next.snap.thd = {thd_l3, thd_l2, thd_l1};
    end

    // Drain one queued record per clock into the ring
    s_next.pend = (s_reg.pend & ~pick_one) | rise;
    if (|s_reg.pend)
    begin
      s_next.hist[s_reg.hist_wr] = s_reg.snap;
      s_next.hist[s_reg.hist_wr].code = pick_code;
      s_next.hist_wr = (s_reg.hist_wr == HIST_LAST) ? '0 :
                       s_reg.hist_wr + 1'b1;
      if (s_reg.hist_fill != HIST_IDX_W'(HIST_DEPTH))
        s_next.hist_fill = s_reg.hist_fill + 1'b1;
    end

    // Sticky interrupts; a new event beats the read-clear
    if (reg_rd && reg_addr == ADDR_INT_STAT)
      s_next.int_stat = int_set;
    else
      s_next.int_stat = s_reg.int_stat | int_set;

    // Register writes
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_CTRL: s_next.enable = reg_wdata[NCH-1:0];
        ADDR_DELAY0: s_next.delay[0] = reg_wdata[DLY_W-1:0];
        ADDR_DELAY0 + 8'h04: s_next.delay[1] = reg_wdata[DLY_W-1:0];
        ADDR_DELAY0 + 8'h08: s_next.delay[2] = reg_wdata[DLY_W-1:0];
        ADDR_THR0: s_next.thr[0] = reg_wdata[THD_W-1:0];
        ADDR_THR0 + 8'h04: s_next.thr[1] = reg_wdata[THD_W-1:0];
        ADDR_THR0 + 8'h08: s_next.thr[2] = reg_wdata[THD_W-1:0];
        ADDR_EVT_MASK: s_next.evt_mask = reg_wdata[NEVT-1:0];
        ADDR_INT_MASK: s_next.int_mask = reg_wdata[2:0];
        ADDR_HIST_SEL: s_next.hist_sel = reg_wdata[HIST_IDX_W-1:0];
        default: s_next.int_mask = s_next.int_mask;
      endcase
    end

    // Register reads; data stand only in the following cycle
    s_next.rdata = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_CTRL: s_next.rdata = 32'(s_reg.enable);
        ADDR_DELAY0: s_next.rdata = 32'(s_reg.delay[0]);
        ADDR_DELAY0 + 8'h04: s_next.rdata = 32'(s_reg.delay[1]);
        ADDR_DELAY0 + 8'h08: s_next.rdata = 32'(s_reg.delay[2]);
        ADDR_THR0: s_next.rdata = 32'(s_reg.thr[0]);
        ADDR_THR0 + 8'h04: s_next.rdata = 32'(s_reg.thr[1]);
        ADDR_THR0 + 8'h08: s_next.rdata = 32'(s_reg.thr[2]);
        ADDR_EVT_MASK: s_next.rdata = 32'(s_reg.evt_mask);
        ADDR_STATUS:
          s_next.rdata = {23'h000000, s_reg.blk_sample, 1'b0, stat_now};
        ADDR_CNT0: s_next.rdata = 32'(s_reg.cnt[0]);
        ADDR_CNT0 + 8'h04: s_next.rdata = 32'(s_reg.cnt[1]);
        ADDR_CNT0 + 8'h08: s_next.rdata = 32'(s_reg.cnt[2]);
        ADDR_INT_STAT: s_next.rdata = 32'(s_reg.int_stat);
        ADDR_INT_MASK: s_next.rdata = 32'(s_reg.int_mask);
        ADDR_HIST_SEL:
          s_next.rdata = {16'h0000, 4'h0, s_reg.hist_fill,
                          4'h0, s_reg.hist_wr};
        ADDR_HIST_TIME: s_next.rdata = rd_rec.stamp;
        ADDR_HIST_INFO:
          s_next.rdata = 32'({rd_rec.group, 5'h00, rd_rec.code});
        ADDR_HIST_THD01:
          s_next.rdata = {2'h0, rd_rec.thd[1], 2'h0, rd_rec.thd[0]};
        ADDR_HIST_THD2: s_next.rdata = 32'(rd_rec.thd[2]);
        default: s_next.rdata = '0;
      endcase
    end
  end

  // ************************************************************
  // State register with reset values
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_reg <= '0;
      s_reg.enable <= ENABLE_RESET;
      s_reg.delay <= {NCH{DELAY_RESET}};
      s_reg.thr <= {NCH{THR_RESET}};
      s_reg.evt_mask <= EVT_MASK_RESET;
    end
    else
      s_reg <= s_next;
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Direct channel flops, usable for relays or user logic
  assign start_out = ch_start;
  assign alarm_out = ch_alarm;
  assign blocked_out = |ch_blocked;
  assign evt_vec = s_reg.evt_vec;
  assign evt_time = s_reg.evt_time;
  assign reg_rdata = s_reg.rdata;
  assign irq = |(s_reg.int_stat & s_reg.int_mask);

endmodule
`default_nettype wire

// ### bench/dme_chk.sv
// Port checker for the distortion alarm block
`timescale 1ns/1ps
`default_nettype none
module dme_chk
  import dme_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = STEP_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Status, events, interrupt
  input wire logic [NCH-1:0] start_out,
  input wire logic [NCH-1:0] alarm_out,
  input wire logic blocked_out,
  input wire logic [NEVT-1:0] evt_vec,
  input wire logic irq
);
  // ***********
  // Helpers
  // ***********
  logic [NSTAT-1:0] stat;
  logic on_any;
  logic [23:0] gap_reg;
  assign stat = {blocked_out, alarm_out, start_out};
  assign on_any = |(evt_vec & 14'h1555);
  // Cycles since status moved; saturates so it never wraps
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      gap_reg <= 24'h0;
    else if ($changed(stat))
      gap_reg <= 24'h0;
    else if (gap_reg != 24'hFFFFFF)
      gap_reg <= gap_reg + 24'h1;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  a_alarm_with_start:
    assert property ((alarm_out & ~start_out) == 3'h0)
    else $error("alarm without start");
  a_start_blk_excl:
    assert property (!(blocked_out && start_out != 3'h0))
    else $error("start and blocked together");
  a_start_on_evt:
    assert property (evt_vec[0] |->
      $past(start_out[0]) && !$past(start_out[0], 2))
    else $error("start on event misplaced");
  a_alarm_off_evt:
    assert property (evt_vec[7] |->
      !$past(alarm_out[0]) && $past(alarm_out[0], 2))
    else $error("alarm off event misplaced");
  a_blk_on_evt:
    assert property (evt_vec[12] |->
      $past(blocked_out) && !$past(blocked_out, 2))
    else $error("blocked on event misplaced");
  a_status_tick:
    assert property ($changed(stat) |-> gap_reg >= TICK_CYCLES - 1)
    else $error("status moved between ticks");
  a_rdata_idle:
    assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data outside read slot");
  a_irq_cause:
    assert property ($rose(irq) |-> on_any
      || (($past(stat) & ~$past(stat, 2)) != 7'h00) || $past(reg_wr))
    else $error("interrupt without cause");
endmodule
bind dme_distortion_monitor_event_block dme_chk #(
  .TICK_CYCLES(TICK_CYCLES)
) chk_u (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .start_out(start_out),
  .alarm_out(alarm_out),
  .blocked_out(blocked_out),
  .evt_vec(evt_vec),
  .irq(irq)
);
`default_nettype wire

// ### bench/dme_relay_model.sv
// Relay side model: blocking matrix, measurements, time, setting group
`timescale 1ns/1ps
`default_nettype none
module dme_relay_model
  import dme_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Requests from the bench
  input wire logic blk_req,
  input wire logic [4:0][THD_W-1:0] thd_req,
  // Toward the block
  output logic block_in,
  output logic [4:0][THD_W-1:0] thd,
  output logic [TS_W-1:0] time_ms,
  output logic [GRP_W-1:0] setting_group
);
  // Levels move just after an edge; time runs one count per clock
  // so stamps can be bounded tightly
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      block_in <= 1'b0;
      thd <= '0;
      time_ms <= 32'h0;
    end
    else
    begin
      block_in <= blk_req;
      thd <= thd_req;
      time_ms <= time_ms + 32'h1;
    end
  end
  // Fixed group; records must carry it
  assign setting_group = 3'h5;
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the distortion alarm block
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dme_pkg::*;
;
  localparam int TK = 8;
  localparam logic [THD_W-1:0] HI = 14'h03E9;
  localparam logic [THD_W-1:0] HOLD = 14'h03CA;
  localparam logic [THD_W-1:0] LOW = 14'h03C9;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic blk_req = 1'b0;
  logic [4:0][THD_W-1:0] thd_req = '0;
  logic [4:0][THD_W-1:0] thd;
  logic [31:0] reg_rdata;
  logic block_in;
  logic [TS_W-1:0] time_ms;
  logic [TS_W-1:0] evt_time;
  logic [GRP_W-1:0] grp;
  logic [NCH-1:0] start_out;
  logic [NCH-1:0] alarm_out;
  logic blocked_out;
  logic irq;
  logic [NEVT-1:0] evt_vec;
  logic [NEVT-1:0] ev_seen = '0;
  logic [NSTAT-1:0] stat;
  logic [31:0] rv;
  int failures = 0;
  int checked = 0;
  assign stat = {blocked_out, alarm_out, start_out};
  // 8 ns clock
  always #4 ref_clk = ~ref_clk;
  dme_relay_model rel_u (.ref_clk(ref_clk), .resetn(resetn),
    .blk_req(blk_req), .thd_req(thd_req), .block_in(block_in), .thd(thd),
    .time_ms(time_ms), .setting_group(grp));
  dme_distortion_monitor_event_block #(.TICK_CYCLES(TK)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .block_in(block_in), .thd_l1(thd[0]),
    .thd_l2(thd[1]), .thd_l3(thd[2]), .thd_residual_current_one(thd[3]),
    .thd_residual_current_two(thd[4]), .time_ms(time_ms),
    .setting_group(grp), .start_out(start_out), .alarm_out(alarm_out),
    .blocked_out(blocked_out), .evt_vec(evt_vec), .evt_time(evt_time),
    .irq(irq));
  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Event log, sampled mid-cycle so launched pulses have settled
  always @(negedge ref_clk)
  begin
    ev_seen <= ev_seen | evt_vec;
    if (evt_vec != 14'h0)
      chk("evt stamp", 32'(time_ms - evt_time < 32'h10), 32'h1);
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask
  task automatic drv(input int i, input logic [THD_W-1:0] v);
    @(posedge ref_clk);
    thd_req[i] <= v;
  endtask
  task automatic blk(input logic v);
    @(posedge ref_clk);
    blk_req <= v;
  endtask
  task automatic ticks(input int n);
    repeat (n * TK) @(posedge ref_clk);
    #1;
  endtask
  // Bounded wait for one status bit
  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    while (stat[b] !== v)
    begin
      @(posedge ref_clk);
      #1;
      n++;
      if (n > 4 * TK)
      begin
        failures++;
        $display("Error status %0d expected %b seen %b", b, v, stat[b]);
        test_done();
      end
    end
  endtask
  task automatic s_regs;
    rd(ADDR_CTRL);
    chk("enable", rv, 32'h7);
    rd(ADDR_DELAY0 + 8'h8);
    chk("delay2", rv, 32'h7D0);
    rd(ADDR_EVT_MASK);
    chk("evt mask", rv, 32'h3FFF);
    rd(8'hFC);
    chk("unmapped", rv, 32'h0);
    wr(ADDR_DELAY0 + 8'h4, 32'h57E40);
    rd(ADDR_DELAY0 + 8'h4);
    chk("delay1 max", rv, 32'h57E40);
  endtask
  task automatic s_alarm;
    wr(ADDR_DELAY0, 32'h3);
    wr(ADDR_CTRL, 32'hF);
    ev_seen = '0;
    drv(1, HI);
    wait_stat(0, 1'b1);
    repeat (3 * TK - 1) @(posedge ref_clk);
    #1;
    chk("alarm early", 32'(alarm_out), 32'h0);
    @(posedge ref_clk);
    #1;
    chk("alarm due", 32'(alarm_out), 32'h1);
    drv(1, HOLD);
    ticks(2);
    chk("held", 32'(stat), 32'h9);
    drv(1, LOW);
    wait_stat(0, 1'b0);
    chk("alarm off", 32'(alarm_out), 32'h0);
    ticks(1);
    chk("events", 32'(ev_seen), 32'hC3);
    rd(ADDR_CNT0 + 8'h4);
    chk("alarm count", rv, 32'h1);
  endtask
  task automatic s_block;
    wr(ADDR_DELAY0 + 8'h4, 32'h2);
    ev_seen = '0;
    drv(3, HI);
    wait_stat(1, 1'b1);
    blk(1'b1);
    wait_stat(6, 1'b1);
    chk("start drop", 32'(start_out), 32'h0);
    ticks(3);
    chk("no alarm", 32'(stat), 32'h40);
    blk(1'b0);
    ticks(2);
    chk("no restart", 32'(stat), 32'h0);
    drv(3, LOW);
    blk(1'b1);
    drv(4, HI);
    ticks(3);
    chk("blocked only", 32'(stat), 32'h40);
    blk(1'b0);
    drv(4, LOW);
    ticks(2);
    chk("events", 32'(ev_seen), 32'h300C);
    rd(ADDR_CNT0 + 8'h8);
    chk("blk count", rv, 32'h2);
    wr(ADDR_CTRL, 32'hE);
    drv(0, HI);
    ticks(3);
    chk("disabled", 32'(stat), 32'h0);
    drv(0, LOW);
    wr(ADDR_CTRL, 32'hF);
    rd(ADDR_CNT0);
    chk("count clr", rv, 32'h0);
  endtask
  task automatic s_mask;
    wr(ADDR_EVT_MASK, 32'h3FEF);
    wr(ADDR_INT_MASK, 32'h1);
    rd(ADDR_INT_STAT);
    ev_seen = '0;
    @(posedge ref_clk);
    thd_req[3] <= HI;
    thd_req[4] <= HI;
    wait_stat(1, 1'b1);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("irq", 32'(irq), 32'h1);
    rd(ADDR_INT_STAT);
    chk("int stat", rv, 32'h1);
    chk("irq clr", 32'(irq), 32'h0);
    @(posedge ref_clk);
    thd_req[3] <= LOW;
    thd_req[4] <= LOW;
    ticks(2);
    chk("masked", 32'(ev_seen), 32'h2C);
    wr(ADDR_EVT_MASK, 32'h3FFF);
  endtask
  task automatic s_hist;
    logic [3:0] b;
    @(posedge ref_clk);
    thd_req[0] <= 14'h0011;
    thd_req[1] <= 14'h0022;
    thd_req[2] <= 14'h0033;
    rd(ADDR_HIST_SEL);
    b = rv[3:0];
    repeat (13)
    begin
      drv(4, HI);
      ticks(1);
      drv(4, LOW);
      ticks(1);
    end
    rd(ADDR_HIST_SEL);
    chk("hist ptr", rv, 32'h0C00 | 32'((b + 4'h1) % 4'hC));
    wr(ADDR_HIST_SEL, 32'(b));
    rd(ADDR_HIST_INFO);
    chk("rec info", rv, 32'h502);
    rd(ADDR_HIST_THD01);
    chk("rec thd01", rv, 32'h00220011);
    rd(ADDR_HIST_THD2);
    chk("rec thd2", rv, 32'h33);
    rd(ADDR_HIST_TIME);
    chk("rec stamp", 32'(time_ms - rv < 32'h40), 32'h1);
  endtask
  initial
  begin
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    s_regs();
    s_alarm();
    s_block();
    s_mask();
    s_hist();
    test_done();
  end
endmodule
`default_nettype wire
